// File: dv/pvah_properties.sv
// Port-level checker for the loop alarm block.
// Assumes it is bound to pvah_top and sees only its ports.
`timescale 1ns/1ps
module pvah_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    // Interrupt
    input wire logic irq
);
    // ----------------------------------------
    // Shadows of mode and mask words
    // ----------------------------------------
    logic [15:0] mode_r, mode_nxt; // Last mode written
    logic [15:0] mask_r, mask_nxt; // Last mask written
    // Next shadow values from the write strobe
    always_comb begin
        mode_nxt = mode_r;
        mask_nxt = mask_r;
        if (wr && addr == pvah_pkg::OFS_MODE) mode_nxt = wdata;
        if (wr && addr == pvah_pkg::OFS_IRQ_MASK) mask_nxt = wdata;
    end
    // Shadow registers, cleared like the block
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= 16'h0000;
            mask_r <= 16'h0000;
        end else begin
            mode_r <= mode_nxt;
            mask_r <= mask_nxt;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // One read strobe at a given word
    sequence rd_of(a);
        rd && addr == a;
    endsequence
    // Write then read of the same word, back to back
    sequence wr_then_rd(a);
        wr && addr == a ##1 rd && addr == a;
    endsequence
    rdata_idle_a: assert property (!rd |=> rdata == 16'h0000) else $error("read data outside its slot");
    hyst_clamp_a: assert property (rd_of(pvah_pkg::OFS_HYST) |=>
        rdata >= pvah_pkg::HYST_MIN && rdata <= pvah_pkg::HYST_MAX) else $error("hysteresis out of range");
    thresh_back_a: assert property (wr_then_rd(pvah_pkg::OFS_HH) |=> rdata == $past(wdata, 2))
        else $error("threshold readback wrong");
    unmapped_zero_a: assert property (rd_of(5'h1F) |=> rdata == 16'h0000) else $error("unmapped read not zero");
    status_resv_a: assert property (rd_of(pvah_pkg::OFS_STATUS) |=> rdata[15:9] == 7'h00)
        else $error("status spare bits set");
    irq_mask_a: assert property (irq |-> (mask_r | $past(mask_r)) != 16'h0000) else $error("irq with mask clear");
    abs_off_a: assert property (rd && addr == pvah_pkg::OFS_STATUS && !mode_r[0] && !$past(mode_r[0]) &&
        !$past(mode_r[0], 2) |=> rdata[3:0] == 4'h0) else $error("absolute alarm while disabled");
    dev_off_a: assert property (rd && addr == pvah_pkg::OFS_STATUS && !mode_r[13] && !$past(mode_r[13]) &&
        !$past(mode_r[13], 2) |=> rdata[5:4] == 2'h0) else $error("deviation alarm while disabled");
endmodule
bind pvah_top pvah_properties pvah_properties_i (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

// File: dv/pvah_top_tb.sv
// Self-checking bench for the loop alarm block.
// Assumes a 20 MHz clock; the divider is set to tick every clock.
`timescale 1ns/1ps
module pvah_top_tb;
    // Table row: inputs and the status word they give
    typedef struct packed { logic [15:0] pv; logic [15:0] sp; logic [15:0] st; } pvah_row_t;
    logic clock, rst_n, wr, rd, irq;
    logic [4:0] addr;
    logic [15:0] wdata, rdata;
    int mismatches, cmp_count, cycles;
    pvah_row_t rows [14];
    logic [20:0] cfg [12]; // Address over data
    logic [31:0] hc [3]; // Written over read hysteresis
    pvah_top pvah_top_i (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq));
    // ----------------------------------------
    // Clock, timeout and bus tasks
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Cut a hang short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            test_done;
        end
    end
    // One-cycle write; a gap cycle keeps strobes from doubling up
    task automatic wreg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // One-cycle read; data taken in the following cycle only
    task automatic rchk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        check(rdata, e);
    endtask
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Status lands one clock after a tick; stop mid-cycle so outputs are settled
    task automatic settle;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic test_done;
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rows = '{'{16'h01F4, 16'h01F4, 16'h0000}, '{16'h0230, 16'h01F4, 16'h0010}, '{16'h0221, 16'h01F4, 16'h0010},
            '{16'h021C, 16'h01F4, 16'h0000}, '{16'h0321, 16'h01F4, 16'h0034}, '{16'h0318, 16'h01F4, 16'h0034},
            '{16'h0316, 16'h01F4, 16'h0030}, '{16'h0385, 16'h01F4, 16'h003C}, '{16'h01F4, 16'h01F4, 16'h0000},
            '{16'h00C7, 16'h01F4, 16'h0032}, '{16'h00D0, 16'h01F4, 16'h0032}, '{16'h0063, 16'h01F4, 16'h0033},
            '{16'h0063, 16'h0063, 16'h0003}, '{16'h01F4, 16'h0063, 16'h0030}};
        cfg = '{21'h15_0000, 21'h0A_0064, 21'h0B_00C8, 21'h0C_0320, 21'h0D_0384, 21'h0F_0032,
            21'h10_0096, 21'h12_000A, 21'h07_01F4, 21'h08_0000, 21'h09_03E8, 21'h00_2001};
        hc = '{32'h0000_0001, 32'h00C9_00C8, 32'h00C8_00C8};
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 5'h00;
        wdata = 16'h0000;
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rchk(pvah_pkg::OFS_STATUS, 16'h0000);
        foreach (cfg[i]) wreg(cfg[i][20:16], cfg[i][15:0]);
        // Alarm table: hysteresis carries from row to row
        foreach (rows[i]) begin
            wreg(pvah_pkg::OFS_SP, rows[i].sp);
            wreg(pvah_pkg::OFS_PV, rows[i].pv);
            settle;
            rchk(pvah_pkg::OFS_STATUS, rows[i].st);
        end
        // Deviation alarms off by mode bit 13
        wreg(pvah_pkg::OFS_MODE, 16'h0001);
        settle;
        rchk(pvah_pkg::OFS_STATUS, 16'h0000);
        // Interrupt: raise, mask, clear by sticky read
        wreg(pvah_pkg::OFS_SP, 16'h01F4);
        settle;
        // Every alarm of the table and the error from zeroed thresholds stuck
        rchk(pvah_pkg::OFS_IRQ_STAT, 16'h007F);
        wreg(pvah_pkg::OFS_IRQ_MASK, 16'h0004);
        wreg(pvah_pkg::OFS_PV, 16'h0321);
        settle;
        check({15'h0000, irq}, 16'h0001);
        wreg(pvah_pkg::OFS_IRQ_MASK, 16'h0000);
        settle;
        check({15'h0000, irq}, 16'h0000);
        wreg(pvah_pkg::OFS_IRQ_MASK, 16'h0004);
        wreg(pvah_pkg::OFS_PV, 16'h01F4);
        settle;
        rchk(pvah_pkg::OFS_IRQ_STAT, 16'h0004);
        settle;
        check({15'h0000, irq}, 16'h0000);
        // Ordering faults raise the programming error
        wreg(pvah_pkg::OFS_LL, 16'h00C8);
        settle;
        rchk(pvah_pkg::OFS_STATUS, 16'h0040);
        wreg(pvah_pkg::OFS_LL, 16'h0064);
        wreg(pvah_pkg::OFS_MODE, 16'h2001);
        wreg(pvah_pkg::OFS_YEL, 16'h0096);
        settle;
        rchk(pvah_pkg::OFS_STATUS, 16'h0040);
        wreg(pvah_pkg::OFS_YEL, 16'h0032);
        // Output pinned at a limit with value off set point
        wreg(pvah_pkg::OFS_OUT, 16'h03E8);
        settle;
        rchk(pvah_pkg::OFS_STATUS, 16'h0000);
        wreg(pvah_pkg::OFS_PV, 16'h01F5);
        settle;
        rchk(pvah_pkg::OFS_STATUS, 16'h0080);
        wreg(pvah_pkg::OFS_OUT, 16'h0000);
        settle;
        rchk(pvah_pkg::OFS_STATUS, 16'h0100);
        // Hysteresis clamps to its range; deviation alarms off so large values stay legal
        wreg(pvah_pkg::OFS_MODE, 16'h0001);
        foreach (hc[i]) begin
            wreg(pvah_pkg::OFS_HYST, hc[i][31:16]);
            rchk(pvah_pkg::OFS_HYST, hc[i][15:0]);
        end
        // Back-to-back write and read, then an unmapped word
        @(posedge clock);
        addr <= pvah_pkg::OFS_HH;
        wdata <= 16'h0390;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        check(rdata, 16'h0390);
        wreg(5'h1F, 16'hFFFF);
        rchk(5'h1F, 16'h0000);
        // Second reset in mid-run
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rchk(pvah_pkg::OFS_HYST, pvah_pkg::HYST_RST);
        rchk(pvah_pkg::OFS_HI, 16'h0000);
        check({15'h0000, irq}, 16'h0000);
        test_done;
    end
endmodule

// File: shared/pvah_pkg.sv
// Constants for the process-value alarm and hysteresis checker.
// Assumes a single 20 MHz clock domain and 16-bit loop table words.
package pvah_pkg;
    // ------------------------------------------------------------
    // Data widths and limits
    // ------------------------------------------------------------
    localparam int DATA_W = 16;                    // Process value width
    localparam logic [15:0] HYST_MIN = 16'h0001;   // Smallest hysteresis
    localparam logic [15:0] HYST_MAX = 16'h00C8;   // Largest hysteresis, 200
    localparam logic [15:0] HYST_RST = 16'h0001;   // Hysteresis reset value
    // ------------------------------------------------------------
    // Mode word fields
    // ------------------------------------------------------------
    localparam int MODE_DEV_EN_BIT = 13;           // Deviation alarm enable
    localparam int MODE_ABS_EN_BIT = 0;            // Absolute alarm enable
    localparam logic [15:0] MODE_RST = 16'h0000;   // Mode word reset value
    // ------------------------------------------------------------
    // Register offsets (word addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_MODE = 5'h00;       // Mode setting word
    localparam logic [4:0] OFS_SP = 5'h02;         // Set point
    localparam logic [4:0] OFS_PV = 5'h03;         // Process value
    localparam logic [4:0] OFS_STATUS = 5'h06;     // Alarm status word
    localparam logic [4:0] OFS_OUT = 5'h07;        // Control output
    localparam logic [4:0] OFS_OUT_LO = 5'h08;     // Output lower limit
    localparam logic [4:0] OFS_OUT_HI = 5'h09;     // Output upper limit
    localparam logic [4:0] OFS_LL = 5'h0A;         // Low-low threshold
    localparam logic [4:0] OFS_LO = 5'h0B;         // Low threshold
    localparam logic [4:0] OFS_HI = 5'h0C;         // High threshold
    localparam logic [4:0] OFS_HH = 5'h0D;         // High-high threshold
    localparam logic [4:0] OFS_YEL = 5'h0F;        // Yellow deviation
    localparam logic [4:0] OFS_RED = 5'h10;        // Red deviation
    localparam logic [4:0] OFS_HYST = 5'h12;       // Hysteresis amount
    localparam logic [4:0] OFS_IRQ_MASK = 5'h13;   // Interrupt mask
    localparam logic [4:0] OFS_IRQ_STAT = 5'h14;   // Sticky event status
    localparam logic [4:0] OFS_SAMPLE = 5'h15;     // Sample divider
    // ------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------
    localparam int ST_LL = 0;                      // Low-low alarm
    localparam int ST_LO = 1;                      // Low alarm
    localparam int ST_HI = 2;                      // High alarm
    localparam int ST_HH = 3;                      // High-high alarm
    localparam int ST_YEL = 4;                     // Yellow deviation alarm
    localparam int ST_RED = 5;                     // Red deviation alarm
    localparam int ST_PERR = 6;                    // Programming error
    localparam int ST_OVF = 7;                     // Output overflow
    localparam int ST_UNF = 8;                     // Output underflow
    localparam int ST_W = 9;                       // Used status bits
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;            // Clock rate
    localparam logic [15:0] SAMPLE_DIV_RST = 16'h0013; // Sample period minus one
endpackage

// File: src/pvah_band.sv
// One alarm comparator with release hysteresis.
// Assumes unsigned operands; enable arrives once per loop sample.
`timescale 1ns/1ps
module pvah_band #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Evaluation
    input wire logic sample_en,
    input wire logic active,
    input wire logic upper,
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] thresh,
    input wire logic [W-1:0] hyst,
    // Result
    output logic alarm
);
    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic alarm_r; // Held alarm state
    logic alarm_nxt; // Next alarm state
    logic [W:0] rel_hi; // Release level below an upper threshold
    logic [W:0] rel_lo; // Release level above a lower threshold

    // Release levels computed one bit wider to keep saturation honest
    always_comb begin
        rel_hi = {1'b0, thresh} - {1'b0, hyst};
        rel_lo = {1'b0, thresh} + {1'b0, hyst};
        alarm_nxt = alarm_r;
        if (!active) begin
            alarm_nxt = 1'b0;
        end else if (sample_en) begin
            if (upper) begin
                if (value > thresh) begin
                    alarm_nxt = 1'b1;
                end else if (rel_hi[W] || ({1'b0, value} <= rel_hi)) begin
                    alarm_nxt = 1'b0;
                end
            end else begin
                if (value < thresh) begin
                    alarm_nxt = 1'b1;
                end else if ({1'b0, value} >= rel_lo) begin
                    alarm_nxt = 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            alarm_r <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
        end
    end

    assign alarm = alarm_r;
endmodule

// File: src/pvah_top.sv
// Alarm evaluation for one control loop: absolute and deviation alarms,
// programming error check and output limit error.
// Assumes a register master that never overlaps read and write strobes.
//
// Functional notes
// - Hysteresis accepted from 1 to 200
// - Alarm true when value passes threshold
// - Alarm asserts at once, no offset
// - Alarm releases after hysteresis back inside
// - Error unless LL<L<H<HH strictly
// - Error unless yellow below red strictly; flagged only while mode bit 13 is set
// - Limit error when output pinned, PV off set point
// - Mode bit 13 enables deviation alarms
// - Four absolute alarms as separate bits
// - Deviation zones follow the set point
// - No hysteresis on rate-of-change alarm
`timescale 1ns/1ps
module pvah_top #(
    parameter int W = pvah_pkg::DATA_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Interrupt
    output logic irq
);
    // W must hold the largest hysteresis and still fit one bus word
    if (W < 8 || W > 16) begin : g_w_check
        $error("pvah_top: W must lie in 8..16");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Low W bits of a bus word
    function automatic logic [W-1:0] lo_w(input logic [15:0] d);
        return d[W-1:0];
    endfunction
    // Zero-extend a value to a bus word
    function automatic logic [15:0] ext(input logic [W-1:0] v);
        return 16'(v);
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [15:0] mode_r, mode_nxt; // Mode setting word
    logic [W-1:0] sp_r, sp_nxt; // Set point
    logic [W-1:0] pv_r, pv_nxt; // Process value
    logic [W-1:0] out_r, out_nxt; // Control output
    logic [W-1:0] olo_r, olo_nxt; // Output lower limit
    logic [W-1:0] ohi_r, ohi_nxt; // Output upper limit
    logic [W-1:0] ll_r, ll_nxt; // Low-low threshold
    logic [W-1:0] lo_r, lo_nxt; // Low threshold
    logic [W-1:0] hi_r, hi_nxt; // High threshold
    logic [W-1:0] hh_r, hh_nxt; // High-high threshold
    logic [W-1:0] yel_r, yel_nxt; // Yellow deviation amount
    logic [W-1:0] red_r, red_nxt; // Red deviation amount
    logic [7:0] hyst_r, hyst_nxt; // Hysteresis amount
    logic [15:0] div_r, div_nxt; // Sample period minus one
    logic [pvah_pkg::ST_W-1:0] mask_r, mask_nxt; // Interrupt mask
    logic [15:0] rdata_r, rdata_nxt; // Read data
    logic [pvah_pkg::ST_W-1:0] stat_w; // Live status bits
    logic [pvah_pkg::ST_W-1:0] sticky_r; // Sticky events
    logic [15:0] hyst_in; // Written hysteresis

    // Writes and the one-cycle read return
    always_comb begin
        mode_nxt = mode_r;
        sp_nxt = sp_r;
        pv_nxt = pv_r;
        out_nxt = out_r;
        olo_nxt = olo_r;
        ohi_nxt = ohi_r;
        ll_nxt = ll_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        hh_nxt = hh_r;
        yel_nxt = yel_r;
        red_nxt = red_r;
        hyst_nxt = hyst_r;
        div_nxt = div_r;
        mask_nxt = mask_r;
        rdata_nxt = 16'h0000;
        hyst_in = wdata;
        // Out-of-range hysteresis is clamped rather than dropped
        if (hyst_in < pvah_pkg::HYST_MIN) begin
            hyst_in = pvah_pkg::HYST_MIN;
        end else if (hyst_in > pvah_pkg::HYST_MAX) begin
            hyst_in = pvah_pkg::HYST_MAX;
        end
        if (wr) begin
            if (addr == pvah_pkg::OFS_MODE) begin
                mode_nxt = wdata;
            end else if (addr == pvah_pkg::OFS_SP) begin
                sp_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_PV) begin
                pv_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_OUT) begin
                out_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_OUT_LO) begin
                olo_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_OUT_HI) begin
                ohi_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_LL) begin
                ll_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_LO) begin
                lo_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_HI) begin
                hi_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_HH) begin
                hh_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_YEL) begin
                yel_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_RED) begin
                red_nxt = lo_w(wdata);
            end else if (addr == pvah_pkg::OFS_HYST) begin
                hyst_nxt = hyst_in[7:0];
            end else if (addr == pvah_pkg::OFS_IRQ_MASK) begin
                mask_nxt = wdata[pvah_pkg::ST_W-1:0];
            end else if (addr == pvah_pkg::OFS_SAMPLE) begin
                div_nxt = wdata;
            end
        end
        if (rd) begin
            if (addr == pvah_pkg::OFS_MODE) begin
                rdata_nxt = mode_r;
            end else if (addr == pvah_pkg::OFS_SP) begin
                rdata_nxt = ext(sp_r);
            end else if (addr == pvah_pkg::OFS_PV) begin
                rdata_nxt = ext(pv_r);
            end else if (addr == pvah_pkg::OFS_STATUS) begin
                rdata_nxt = {{(16-pvah_pkg::ST_W){1'b0}}, stat_w};
            end else if (addr == pvah_pkg::OFS_OUT) begin
                rdata_nxt = ext(out_r);
            end else if (addr == pvah_pkg::OFS_OUT_LO) begin
                rdata_nxt = ext(olo_r);
            end else if (addr == pvah_pkg::OFS_OUT_HI) begin
                rdata_nxt = ext(ohi_r);
            end else if (addr == pvah_pkg::OFS_LL) begin
                rdata_nxt = ext(ll_r);
            end else if (addr == pvah_pkg::OFS_LO) begin
                rdata_nxt = ext(lo_r);
            end else if (addr == pvah_pkg::OFS_HI) begin
                rdata_nxt = ext(hi_r);
            end else if (addr == pvah_pkg::OFS_HH) begin
                rdata_nxt = ext(hh_r);
            end else if (addr == pvah_pkg::OFS_YEL) begin
                rdata_nxt = ext(yel_r);
            end else if (addr == pvah_pkg::OFS_RED) begin
                rdata_nxt = ext(red_r);
            end else if (addr == pvah_pkg::OFS_HYST) begin
                rdata_nxt = {8'h00, hyst_r};
            end else if (addr == pvah_pkg::OFS_IRQ_MASK) begin
                rdata_nxt = {{(16-pvah_pkg::ST_W){1'b0}}, mask_r};
            end else if (addr == pvah_pkg::OFS_IRQ_STAT) begin
                rdata_nxt = {{(16-pvah_pkg::ST_W){1'b0}}, sticky_r};
            end else if (addr == pvah_pkg::OFS_SAMPLE) begin
                rdata_nxt = div_r;
            end
        end
    end

    // Register file storage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= pvah_pkg::MODE_RST;
            sp_r <= '0;
            pv_r <= '0;
            out_r <= '0;
            olo_r <= '0;
            ohi_r <= '0;
            ll_r <= '0;
            lo_r <= '0;
            hi_r <= '0;
            hh_r <= '0;
            yel_r <= '0;
            red_r <= '0;
            hyst_r <= pvah_pkg::HYST_RST[7:0];
            div_r <= pvah_pkg::SAMPLE_DIV_RST;
            mask_r <= '0;
            rdata_r <= 16'h0000;
        end else begin
            mode_r <= mode_nxt;
            sp_r <= sp_nxt;
            pv_r <= pv_nxt;
            out_r <= out_nxt;
            olo_r <= olo_nxt;
            ohi_r <= ohi_nxt;
            ll_r <= ll_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            hh_r <= hh_nxt;
            yel_r <= yel_nxt;
            red_r <= red_nxt;
            hyst_r <= hyst_nxt;
            div_r <= div_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign rdata = rdata_r;

    // ------------------------------------------------------------
    // Loop sample divider
    // ------------------------------------------------------------
    logic [15:0] cnt_r, cnt_nxt; // Cycles left in this sample
    logic tick_r, tick_nxt; // One-cycle sample enable

    // Counts down from the programmed period, pulses at zero
    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0000) begin
            cnt_nxt = div_r;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ------------------------------------------------------------
    // Alarm comparators
    // ------------------------------------------------------------
    logic [W-1:0] dev_w; // Distance from set point
    logic [W-1:0] hyst_w; // Hysteresis at data width
    logic dev_en_w; // Deviation alarms enabled
    logic abs_en_w; // Absolute alarms enabled
    logic a_ll, a_lo, a_hi, a_hh, a_yel, a_red; // Alarm states

    // Deviation measured against the current set point, so zones move with it
    assign dev_w = (pv_r >= sp_r) ? (pv_r - sp_r) : (sp_r - pv_r);
    assign hyst_w = W'(hyst_r);
    assign dev_en_w = mode_r[pvah_pkg::MODE_DEV_EN_BIT];
    assign abs_en_w = mode_r[pvah_pkg::MODE_ABS_EN_BIT];

    // Hysteresis applies to these bands only; no rate-of-change path exists
    pvah_band #(.W(W)) u_ll (.clock(clock), .rst_n(rst_n), .sample_en(tick_r), .active(abs_en_w),
        .upper(1'b0), .value(pv_r), .thresh(ll_r), .hyst(hyst_w), .alarm(a_ll));
    pvah_band #(.W(W)) u_lo (.clock(clock), .rst_n(rst_n), .sample_en(tick_r), .active(abs_en_w),
        .upper(1'b0), .value(pv_r), .thresh(lo_r), .hyst(hyst_w), .alarm(a_lo));
    pvah_band #(.W(W)) u_hi (.clock(clock), .rst_n(rst_n), .sample_en(tick_r), .active(abs_en_w),
        .upper(1'b1), .value(pv_r), .thresh(hi_r), .hyst(hyst_w), .alarm(a_hi));
    pvah_band #(.W(W)) u_hh (.clock(clock), .rst_n(rst_n), .sample_en(tick_r), .active(abs_en_w),
        .upper(1'b1), .value(pv_r), .thresh(hh_r), .hyst(hyst_w), .alarm(a_hh));
    pvah_band #(.W(W)) u_yel (.clock(clock), .rst_n(rst_n), .sample_en(tick_r), .active(dev_en_w),
        .upper(1'b1), .value(dev_w), .thresh(yel_r), .hyst(hyst_w), .alarm(a_yel));
    pvah_band #(.W(W)) u_red (.clock(clock), .rst_n(rst_n), .sample_en(tick_r), .active(dev_en_w),
        .upper(1'b1), .value(dev_w), .thresh(red_r), .hyst(hyst_w), .alarm(a_red));

    // ------------------------------------------------------------
    // Error checks, sampled once per loop sample
    // ------------------------------------------------------------
    logic perr_r, perr_nxt; // Programming error
    logic ovf_r, ovf_nxt; // Output pinned high, PV off set point
    logic unf_r, unf_nxt; // Output pinned low, PV off set point

    // Limits assumed distinct by software; equal limits flag both when the output sits on them
    always_comb begin
        perr_nxt = perr_r;
        ovf_nxt = ovf_r;
        unf_nxt = unf_r;
        if (tick_r) begin
            perr_nxt = !((ll_r < lo_r) && (lo_r < hi_r) && (hi_r < hh_r));
            if (dev_en_w && !(yel_r < red_r)) begin
                perr_nxt = 1'b1;
            end
            ovf_nxt = (out_r >= ohi_r) && (pv_r != sp_r);
            unf_nxt = (out_r <= olo_r) && (pv_r != sp_r);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            perr_r <= 1'b0;
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
        end else begin
            perr_r <= perr_nxt;
            ovf_r <= ovf_nxt;
            unf_r <= unf_nxt;
        end
    end

    assign stat_w = {unf_r, ovf_r, perr_r, a_red, a_yel, a_hh, a_hi, a_lo, a_ll};

    // ------------------------------------------------------------
    // Sticky events and interrupt
    // ------------------------------------------------------------
    logic [pvah_pkg::ST_W-1:0] sticky_nxt; // Next sticky events
    logic irq_r, irq_nxt; // Interrupt level

    // Read clears; a rising status bit in the same cycle still lands
    always_comb begin
        sticky_nxt = sticky_r;
        if (rd && (addr == pvah_pkg::OFS_IRQ_STAT)) begin
            sticky_nxt = '0;
        end
        sticky_nxt = sticky_nxt | stat_w;
        irq_nxt = |(sticky_nxt & mask_nxt);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sticky_r <= '0;
            irq_r <= 1'b0;
        end else begin
            sticky_r <= sticky_nxt;
            irq_r <= irq_nxt;
        end
    end
    assign irq = irq_r;
endmodule
